//--- design/trace_macrocell_config_regs.v
// Trace configuration, identification and trace-enable control bank
// Function
// (RQ1) Config code reports four comparator pairs, two counters, one context comparator.
// (RQ2) Config code reports two external outputs and four external inputs.
// (RQ3) Config code sets id, software access, start/stop, sequencer; others zero.
// (RQ4) System config reads entirely zero, including processor count and fifo flag.
// (RQ5) Start/stop bits 23..16 pick single comparators 1..8 as stop points.
// (RQ6) Start/stop bits 7..0 pick single comparators 1..8 as start points.
// (RQ7) Start/stop enable clear ignores start/stop; set follows it.
// (RQ8) Start/stop state keeps running whatever the enable bit holds.
// (RQ9) Include mode traces only inside selected range regions.
// (RQ10) Exclude mode traces whenever outside every selected range region.
// (RQ11) Control low nibble picks range comparators 1..4 for filtering.
// (RQ12) Software traces everything with exclude only and always-true event code.
// (RQ13) Sync frequency low three bits are absent and read zero.
// (RQ14) Identification feature bits and fixed fields read as documented.
// (RQ15) Identification holds implementer byte and version and revision nibbles.
// (RQ16) Extension reports 64-bit binary timestamps, no barrier timestamps.
// (RQ17) Extension reports return stack, virtualization, full counters, fixed bits.
// (RQ18) Extension reports input bus size 88, two selectors, registers readable.
// (RQ19) Every register is one 32-bit word at its offset from base.
// (RQ20) Writes to read-only registers change nothing.
`include "trace_cfg_defines.vh"

module trace_macrocell_config_regs (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [7:0] single_hit,
  input wire [3:0] range_hit,
  output reg trace_enable,
  output wire start_stop_active,
  output wire [31:0] trace_enable_event,
  output wire [31:0] sync_period
);

  reg [31:0] start_stop_sel;
  reg [31:0] trace_ctrl;
  reg [31:0] trace_event;
  reg [31:0] sync_freq;
  reg [31:0] read_mux;
  wire [31:0] config_code;
  wire [31:0] system_config;
  wire [31:0] arch_id;
  wire [31:0] config_ext;
  wire setup;
  wire wr_access;
  wire [3:0] range_sel;
  wire in_region;
  wire filter_ok;
  wire gate_ok;
  wire next_trace_enable;

  // Fixed identification words; built from wires, no storage to write
  assign config_code = {1'b1, 3'h0, 1'b1, 1'b1, `CC_CTXID_CMP, 1'b0,
                        `CC_EXT_OUTS, `CC_EXT_INS, 1'b1, `CC_COUNTERS,
                        9'h000, `CC_ADDR_PAIRS}; // see (RQ1) (RQ2) (RQ3)
  assign system_config = `WORD_ZERO; // see (RQ4)
  assign arch_id = {`ID_IMPLEMENTER, 3'h0, 1'b1, 1'b1, 1'b1, 2'h0, 4'hf,
                    `ID_MAJOR, `ID_MINOR, `ID_REVISION}; // see (RQ14) (RQ15)
  assign config_ext = {2'h0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1,
                       1'b1, 6'h00, `CCE_INSTR_RES, 1'b1, 1'b1,
                       `CCE_EXT_BUS_SIZE,
                       `CCE_EXT_SELECTORS}; // see (RQ16) (RQ17) (RQ18)

  // Zero wait states while enabled; a frozen block stretches the access
  assign pready = ce;
  assign pslverr = 1'b0;
  assign setup = psel & ~penable;
  assign wr_access = psel & penable & pwrite & ce;

  // Word decode on the full offset; unmapped reads return zero
  always @* begin
    read_mux = `WORD_ZERO;
    case (paddr)
      `OFS_CONFIG_CODE: begin
        read_mux = config_code;
      end
      `OFS_SYSTEM_CONFIG: begin
        read_mux = system_config;
      end
      `OFS_START_STOP: begin
        read_mux = start_stop_sel;
      end
      `OFS_TRACE_EVENT: begin
        read_mux = trace_event;
      end
      `OFS_TRACE_CTRL: begin
        read_mux = trace_ctrl;
      end
      `OFS_SYNC_FREQ: begin
        read_mux = sync_freq & `SYNC_MASK; // see (RQ13)
      end
      `OFS_ARCH_ID: begin
        read_mux = arch_id;
      end
      `OFS_CONFIG_EXT: begin
        read_mux = config_ext;
      end
      default: begin
        read_mux = `WORD_ZERO; // see (RQ19)
      end
    endcase
  end

  // Read data captured in the setup phase so it stands in the access phase
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= `WORD_ZERO;
    end else if (ce && setup && !pwrite) begin
      prdata <= read_mux;
    end
  end

  // Only writable words decode; read-only offsets fall to default
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      start_stop_sel <= `SS_RESET;
      trace_ctrl <= `TEC_RESET;
      trace_event <= `TEE_RESET;
      sync_freq <= `SYNC_RESET;
    end else if (wr_access) begin
      case (paddr)
        `OFS_START_STOP: begin
          start_stop_sel <= pwdata & `SS_MASK; // see (RQ5) (RQ6)
        end
        `OFS_TRACE_EVENT: begin
          trace_event <= pwdata & `TEE_MASK;
        end
        `OFS_TRACE_CTRL: begin
          trace_ctrl <= pwdata & `TEC_MASK; // see (RQ11)
        end
        `OFS_SYNC_FREQ: begin
          sync_freq <= pwdata & `SYNC_MASK; // see (RQ13)
        end
        default: begin
          start_stop_sel <= start_stop_sel; // see (RQ20)
        end
      endcase
    end
  end

  // Runs regardless of the enable bit so the event resource stays live
  start_stop_latch u_start_stop (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .start_sel(start_stop_sel[`SS_START_HI:`SS_START_LO]),
    .stop_sel(start_stop_sel[`SS_STOP_HI:`SS_STOP_LO]),
    .single_hit(single_hit),
    .active(start_stop_active)
  ); // see (RQ8)

  assign range_sel = trace_ctrl[`TEC_RANGE_HI:`TEC_RANGE_LO];
  assign in_region = |(range_sel & range_hit); // see (RQ11)
  // Exclude with nothing selected traces everything while start/stop gating is off
  assign filter_ok = trace_ctrl[`TEC_EXCLUDE] ? ~in_region // see (RQ10)
                                              : in_region; // see (RQ9)
  assign gate_ok = trace_ctrl[`TEC_SS_ENABLE] ? start_stop_active
                                              : 1'b1; // see (RQ7)
  assign next_trace_enable = filter_ok & gate_ok;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      trace_enable <= 1'b0;
    end else if (ce) begin
      trace_enable <= next_trace_enable;
    end
  end

  // Event word evaluated by downstream logic; always-true code traces all
  assign trace_enable_event = trace_event; // see (RQ12)
  assign sync_period = sync_freq & `SYNC_MASK;

endmodule

//--- design/trace_cfg_defines.vh
// Register map, field layout and fixed values of the trace configuration bank
`ifndef TRACE_CFG_DEFINES_VH
`define TRACE_CFG_DEFINES_VH

// Byte offsets on the debug peripheral bus
`define OFS_CONFIG_CODE 12'h004
`define OFS_SYSTEM_CONFIG 12'h014
`define OFS_START_STOP 12'h018
`define OFS_TRACE_EVENT 12'h020
`define OFS_TRACE_CTRL 12'h024
`define OFS_SYNC_FREQ 12'h1e0
`define OFS_ARCH_ID 12'h1e4
`define OFS_CONFIG_EXT 12'h1e8

// Start/stop select fields
`define SS_STOP_HI 23
`define SS_STOP_LO 16
`define SS_START_HI 7
`define SS_START_LO 0
`define SS_MASK 32'h00ff00ff

// Trace enable control fields
`define TEC_SS_ENABLE 25
`define TEC_EXCLUDE 24
`define TEC_RANGE_HI 3
`define TEC_RANGE_LO 0
`define TEC_MASK 32'h0300000f

// Sync frequency: low three bits are absent
`define SYNC_MASK 32'h00000ff8
`define SYNC_RESET 32'h00000400

// Reset values of writable registers, and the trace event write mask
`define SS_RESET 32'h00000000
`define TEC_RESET 32'h00000000
`define TEE_RESET 32'h00000000
`define TEE_MASK 32'h0001ffff

// Configuration code fields
`define CC_ADDR_PAIRS 4'h4
`define CC_COUNTERS 3'h2
`define CC_CTXID_CMP 2'h1
`define CC_EXT_OUTS 3'h2
`define CC_EXT_INS 3'h4

// Identification fields; codes below are arbitrary
`define ID_IMPLEMENTER 8'h5a
`define ID_MAJOR 4'h7
`define ID_MINOR 4'h6
`define ID_REVISION 4'h5

// Configuration extension fields
`define CCE_EXT_BUS_SIZE 8'h58
`define CCE_EXT_SELECTORS 3'h2
`define CCE_INSTR_RES 3'h0

`define WORD_ZERO 32'h00000000

`endif

//--- design/start_stop_latch.v
// Start/stop state holder driven by single address comparator hits
module start_stop_latch (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire [7:0] start_sel,
  input wire [7:0] stop_sel,
  input wire [7:0] single_hit,
  output reg active
);

  wire start_hit;
  wire stop_hit;
  reg next_active;

  // Bit n of each select picks comparator n+1
  assign start_hit = |(start_sel & single_hit); // see (RQ6)
  assign stop_hit = |(stop_sel & single_hit); // see (RQ5)

  // Stop wins when both hit, so a shared address closes the window
  always @* begin
    next_active = active;
    if (stop_hit) begin
      next_active = 1'b0;
    end else if (start_hit) begin
      next_active = 1'b1;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      active <= 1'b0;
    end else if (ce) begin
      active <= next_active;
    end
  end

endmodule

//--- dv/trace_cfg_assertions.sv
// Port assertions for the trace configuration bank
`include "trace_cfg_defines.vh"
module trace_cfg_checker (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [7:0] single_hit,
  input wire trace_enable,
  input wire start_stop_active,
  input wire [31:0] sync_period
);
  // Read data is captured at the setup edge, so look one cycle on
  wire rd = psel & ~penable & ~pwrite & ce;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_cc_value: assert property (
    rd && paddr == 12'h004 |=> prdata == 32'h8d294004)
    else $error("config code word wrong");
  chk_sc_value: assert property (
    rd && paddr == 12'h014 |=> prdata == 32'h00000000)
    else $error("system config word wrong");
  chk_id_value: assert property (
    rd && paddr == 12'h1e4 |=> prdata == {`ID_IMPLEMENTER, 12'h1cf,
    `ID_MAJOR, `ID_MINOR, `ID_REVISION}) else $error("id word wrong");
  chk_ext_value: assert property (
    rd && paddr == 12'h1e8 |=> prdata == 32'h34c01ac2)
    else $error("extension word wrong");
  chk_hole_zero: assert property (
    rd && paddr == 12'h100 |=> prdata == 32'h00000000)
    else $error("unmapped word not zero");
  chk_sync_low: assert property (sync_period[2:0] == 3'h0)
    else $error("sync low bits set");
  chk_hold_no_hit: assert property (
    ce && single_hit == 8'h00 |=> $stable(start_stop_active))
    else $error("start stop state moved without a hit");
  chk_freeze_ce: assert property (!ce |=> $stable(trace_enable))
    else $error("trace enable moved while frozen");
  chk_ready_ce: assert property (pready == ce && !pslverr)
    else $error("ready or error response wrong");
endmodule
bind trace_macrocell_config_regs trace_cfg_checker u_chk (.clk(clk),
  .reset(reset), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .single_hit(single_hit), .trace_enable(trace_enable),
  .start_stop_active(start_stop_active), .sync_period(sync_period));

//--- dv/trace_macrocell_config_regs_tb_top.sv
// Self-checking bench for the trace configuration bank
`include "trace_cfg_defines.vh"
module trace_macrocell_config_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, ss, ctrl, v;
  logic [7:0] single_hit = 0;
  logic [3:0] range_hit = 0;
  logic act, te;
  wire [31:0] prdata, tee, sync_period;
  wire pready, pslverr, trace_enable, start_stop_active;
  integer error_cnt = 0, samples_checked = 0, seed = 32'h9baa, i;
  logic [11:0] ro_a [5] = '{12'h004, 12'h014, 12'h1e4, 12'h1e8, 12'h100};
  logic [31:0] ro_v [5] = '{32'h8d294004, 32'h0, {`ID_IMPLEMENTER, 12'h1cf,
    `ID_MAJOR, `ID_MINOR, `ID_REVISION}, 32'h34c01ac2, 32'h0};
  always #50 clk = ~clk;
  trace_macrocell_config_regs dut (.clk(clk), .reset(reset), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .single_hit(single_hit), .range_hit(range_hit),
    .trace_enable(trace_enable), .start_stop_active(start_stop_active),
    .trace_enable_event(tee), .sync_period(sync_period));
  task check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Inputs move on the falling edge, away from the sampling edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer n;
    @(negedge clk);
    psel = 1;
    pwrite = w;
    paddr = a;
    pwdata = d;
    @(negedge clk);
    penable = 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      check("pready", 0, 1);
      give_verdict();
    end
    #1 rd = prdata;
    @(negedge clk);
    psel = 0;
    penable = 0;
  endtask
  function logic tr_exp(input logic [31:0] c, input logic [3:0] r,
    input logic a);
    logic hit;
    hit = |(c[3:0] & r);
    return (c[24] ? ~hit : hit) & (c[25] ? a : 1'b1);
  endfunction
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    reset = 0;
    // Fixed words must survive an all-ones write
    for (i = 0; i < 5; i++) begin
      apb(1, ro_a[i], 32'hffffffff);
      apb(0, ro_a[i], 0);
      check("fixed word", rd, ro_v[i]);
    end
    apb(0, 12'h1e0, 0);
    check("sync reset", rd, `SYNC_RESET);
    v = $random(seed);
    apb(1, 12'h1e0, v);
    apb(0, 12'h1e0, 0);
    check("sync", rd, v & 32'h00000ff8);
    check("sync out", sync_period, v & 32'h00000ff8);
    $display("register test done");
    apb(1, 12'h020, 32'h0000006f);
    apb(1, 12'h024, 32'h01000000);
    check("event", tee, 32'h0000006f);
    @(negedge clk);
    check("trace all", trace_enable, 1);
    $display("trace all test done");
    act = 0;
    for (i = 0; i < 60; i++) begin
      ss = $random(seed);
      ctrl = $random(seed);
      // First passes walk every gating and filter mode
      if (i < 4) ctrl[25:24] = i[1:0];
      apb(1, 12'h018, ss);
      apb(1, 12'h024, ctrl);
      apb(0, 12'h018, 0);
      check("start stop", rd, ss & 32'h00ff00ff);
      apb(0, 12'h024, 0);
      check("control", rd, ctrl & 32'h0300000f);
      v = $random(seed);
      @(negedge clk);
      single_hit = v[7:0];
      range_hit = v[11:8];
      @(negedge clk);
      single_hit = 0;
      // Stop beats start when both hit together
      act = |(v[7:0] & ss[23:16]) ? 1'b0 : |(v[7:0] & ss[7:0]) ? 1'b1 : act;
      check("latch", start_stop_active, act);
      @(negedge clk);
      check("trace", trace_enable, tr_exp(ctrl, v[11:8], act));
    end
    $display("trace path test done");
    te = tr_exp(ctrl, v[11:8], act);
    ce = 0;
    range_hit = ~range_hit;
    single_hit = 8'hff;
    @(negedge clk);
    check("ready", pready, 0);
    check("frozen", start_stop_active, act);
    check("frozen trace", trace_enable, te);
    single_hit = 0;
    ce = 1;
    $display("freeze test done");
    give_verdict();
  end
endmodule
